// ==== dcp_pkg.sv ====
// constants for the disc player command interpreter
// assumes a 20 MHz apb clock and ascii characters from the host
`default_nettype none
package dcp_pkg;
  // apb register byte addresses
  localparam logic [11:0] ADDR_RX   = 12'h000;
  localparam logic [11:0] ADDR_TX   = 12'h004;
  localparam logic [11:0] ADDR_STAT = 12'h008;
  // status register field positions
  localparam int STAT_AVAIL  = 0;
  localparam int STAT_BUSY   = 1;
  localparam int STAT_FWD    = 2;
  localparam int STAT_REV    = 3;
  localparam int STAT_ATYPE  = 4;
  localparam int STAT_MARK   = 6;
  localparam int STAT_KLOCK  = 7;
  localparam int STAT_CHAN   = 8;
  localparam int STAT_PROTO  = 10;
  localparam int STAT_LEVEL  = 16;
  // timing
  localparam int CLK_HZ      = 20_000_000;
  localparam int SCAN_TIME_S = 15;
  localparam int SCAN_CYCLES = SCAN_TIME_S * CLK_HZ;
  localparam int SCAN_W      = 29;
  localparam int ATTEN_DB    = 12;
  // widths and reset values
  localparam int BCD6_W = 24;
  localparam int RESP_W = 56;
  localparam logic [7:0] LEVEL_RST = 8'hff;
  localparam logic [1:0] CHAN_RST  = 2'h3;
  localparam logic [1:0] PROTO_MODE = 2'h3;
  // characters
  localparam logic [7:0] CH_R  = 8'h52;
  localparam logic [7:0] CH_E  = 8'h45;
  localparam logic [7:0] CH_0  = 8'h30;
  localparam logic [7:0] CH_1  = 8'h31;
  localparam logic [7:0] CH_4  = 8'h34;
  localparam logic [7:0] CH_9  = 8'h39;
  localparam logic [7:0] CH_X  = 8'h58;
  localparam logic [7:0] CH_A  = 8'h41;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_SP = 8'h20;
  // two-character command codes
  localparam logic [15:0] CMD_FWD    = 16'h4e46;
  localparam logic [15:0] CMD_REV    = 16'h4e52;
  localparam logic [15:0] CMD_LOCATE = 16'h5345;
  localparam logic [15:0] CMD_MARK   = 16'h534d;
  localparam logic [15:0] CMD_BLK    = 16'h424b;
  localparam logic [15:0] CMD_TIME   = 16'h544d;
  localparam logic [15:0] CMD_SONG   = 16'h5452;
  localparam logic [15:0] CMD_IDX    = 16'h4958;
  localparam logic [15:0] CMD_CANCEL = 16'h434c;
  localparam logic [15:0] CMD_FINAL  = 16'h4c4f;
  localparam logic [15:0] CMD_LEVEL  = 16'h564c;
  localparam logic [15:0] CMD_CHAN   = 16'h4144;
  localparam logic [15:0] CMD_PROTO  = 16'h434d;
  localparam logic [15:0] CMD_KLOCK  = 16'h4b4c;
  localparam logic [15:0] QRY_BLK    = 16'h3f42;
  localparam logic [15:0] QRY_TIME   = 16'h3f54;
  localparam logic [15:0] QRY_SONG   = 16'h3f52;
  localparam logic [15:0] QRY_IDX    = 16'h3f31;
  typedef enum logic [1:0] {
    AT_BLOCK = 2'h0,
    AT_TIME  = 2'h1,
    AT_SONG  = 2'h2,
    AT_INDEX = 2'h3
  } dcp_atype_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEEK = 2'b10
  } dcp_state_e;
endpackage : dcp_pkg
`default_nettype wire

// ==== dcp_cmd_interp.sv ====
// command interpreter: parses host characters written over apb, drives the mechanism
// assumes mechanism status inputs are on pclk; host reads replies from the tx register
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module dcp_cmd_interp #(
  parameter int unsigned SCAN_CYCLES_P = dcp_pkg::SCAN_CYCLES
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        mech_playing,
  input  wire logic                        mech_parked,
  input  wire logic                        mech_lead_in,
  input  wire logic                        mech_lead_out,
  input  wire logic                        seek_done,
  input  wire logic                        reject_seen,
  input  wire logic [dcp_pkg::BCD6_W-1:0]  cur_block,
  input  wire logic [15:0]                 cur_time,
  input  wire logic [7:0]                  cur_track,
  input  wire logic [7:0]                  cur_index,
  output logic                             seek_req,
  output logic      [dcp_pkg::BCD6_W-1:0]  seek_addr,
  output logic      [1:0]                  seek_type,
  output logic                             seek_lead_out,
  output logic                             pause_req,
  output logic                             cancel_req,
  output logic                             scan_fwd,
  output logic                             scan_rev,
  output logic                             atten_12db,
  output logic      [7:0]                  level,
  output logic                             chan_left,
  output logic                             chan_right,
  output logic                             keys_locked,
  output logic      [1:0]                  comm_mode
);
  import dcp_pkg::*;

  function automatic logic is_digit(input logic [7:0] c);
    return c >= CH_0 && c <= CH_9;
  endfunction : is_digit

  function automatic logic [47:0] to_ascii(input logic [23:0] b);
    logic [47:0] r;
    r = '0;
    for (int i = 0; i < 6; i++) begin
      r[i*8 +: 8] = {4'h3, b[i*4 +: 4]};
    end
    return r;
  endfunction : to_ascii

  logic              rx_stb_q;
  logic [7:0]        rx_char_q;
  logic              have_first_q;
  logic [7:0]        first_q;
  logic [BCD6_W-1:0] dig_q;
  logic [2:0]        dig_cnt_q;
  logic              lead_q;
  dcp_atype_e        atype_q;
  dcp_state_e        state_q;
  logic              marker_valid_q;
  logic [BCD6_W-1:0] marker_addr_q;
  dcp_atype_e        marker_type_q;
  logic              marker_lead_q;
  logic [SCAN_W-1:0] scan_cnt_q;
  logic [RESP_W-1:0] resp_q;
  logic [2:0]        resp_cnt_q;
  logic [RESP_W-1:0] resp_d;
  logic [2:0]        resp_len_d;
  logic [15:0]       cmd;
  logic              is_fill, digit_in, cmd_stb, cmd_err, cmd_ok, busy;
  logic              known, bad_arg, has_arg, arg_big, is_flag;
  logic [9:0]        arg_bin;
  logic              do_fwd, do_rev, do_locate, do_mark, do_cancel, do_final;
  logic              seek_end, marker_hit, resp_load, tx_pop, apb_wr;
  logic [BCD6_W-1:0] cur_sel;
  logic [47:0]       a_blk, a_tim, a_idx;

  // apb slave, zero wait states; read data is latched in the setup cycle
  assign apb_wr = psel && penable && pwrite;
  assign tx_pop = psel && penable && !pwrite && paddr == ADDR_TX;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= 1'b1;
      pslverr <= psel && !penable &&
                 !(paddr == ADDR_RX || paddr == ADDR_TX || paddr == ADDR_STAT);
      if (psel && !penable) begin
        prdata <= 32'h0000_0000;
        if (paddr == ADDR_TX) begin
          prdata <= {23'h0, resp_cnt_q != 3'h0, resp_q[RESP_W-1 -: 8]};
        end else if (paddr == ADDR_STAT) begin
          prdata[STAT_AVAIL]        <= resp_cnt_q != 3'h0;
          prdata[STAT_BUSY]         <= busy;
          prdata[STAT_FWD]          <= scan_fwd;
          prdata[STAT_REV]          <= scan_rev;
          prdata[STAT_ATYPE +: 2]   <= atype_q;
          prdata[STAT_MARK]         <= marker_valid_q;
          prdata[STAT_KLOCK]        <= keys_locked;
          prdata[STAT_CHAN +: 2]    <= {chan_right, chan_left};
          prdata[STAT_PROTO +: 2]   <= comm_mode;
          prdata[STAT_LEVEL +: 8]   <= level;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_stb_q  <= 1'b0;
      rx_char_q <= 8'h00;
    end else begin
      rx_stb_q <= apb_wr && paddr == ADDR_RX;
      if (apb_wr && paddr == ADDR_RX) begin
        rx_char_q <= pwdata[7:0];
      end
    end
  end

  // character classification and command decode
  assign is_fill  = rx_char_q == CH_CR || rx_char_q == CH_LF || rx_char_q == CH_SP;
  assign digit_in = rx_stb_q && !have_first_q && is_digit(rx_char_q);
  assign cmd_stb  = rx_stb_q && have_first_q && !is_fill;
  assign cmd      = {first_q, rx_char_q};
  assign has_arg  = dig_cnt_q != 3'h0;
  assign arg_big  = dig_cnt_q > 3'h3 && dig_q[23:12] != 12'h000;
  assign arg_bin  = 10'(dig_q[11:8]) * 10'd100 + 10'(dig_q[7:4]) * 10'd10 + 10'(dig_q[3:0]);
  assign is_flag  = cmd == CMD_BLK || cmd == CMD_TIME || cmd == CMD_SONG || cmd == CMD_IDX;

  always_comb begin
    known   = 1'b1;
    bad_arg = 1'b0;
    case (cmd)
      CMD_LEVEL: bad_arg = !has_arg || arg_big || arg_bin > 10'd255;
      CMD_CHAN:  bad_arg = !has_arg || arg_big || arg_bin > 10'd7;
      CMD_PROTO: bad_arg = !has_arg || arg_big || arg_bin != 10'(PROTO_MODE);
      CMD_KLOCK: bad_arg = !has_arg || arg_big || arg_bin > 10'd1;
      CMD_FWD, CMD_REV, CMD_LOCATE, CMD_MARK, CMD_BLK, CMD_TIME, CMD_SONG, CMD_IDX,
      CMD_CANCEL, CMD_FINAL, QRY_BLK, QRY_TIME, QRY_SONG, QRY_IDX: known = 1'b1;
      default:   known = 1'b0;
    endcase
  end

  // only cancel may interrupt a search in progress
  assign busy      = state_q == ST_SEEK;
  assign cmd_err   = cmd_stb && (!known || bad_arg || (busy && cmd != CMD_CANCEL));
  assign cmd_ok    = cmd_stb && !cmd_err;
  assign do_fwd    = cmd_ok && cmd == CMD_FWD;
  assign do_rev    = cmd_ok && cmd == CMD_REV;
  assign do_locate = cmd_ok && cmd == CMD_LOCATE;
  assign do_mark   = cmd_ok && cmd == CMD_MARK;
  assign do_cancel = cmd_ok && cmd == CMD_CANCEL;
  assign do_final  = cmd_ok && cmd == CMD_FINAL;
  assign seek_end  = busy && (seek_done || do_cancel);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      have_first_q <= 1'b0;
      first_q      <= 8'h00;
    end else if (rx_stb_q && !is_fill) begin
      have_first_q <= !have_first_q && !is_digit(rx_char_q);
      if (!have_first_q) begin
        first_q <= rx_char_q;
      end
    end
  end

  // digit buffer keeps the last six digits; flags leave it alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dig_q     <= '0;
      dig_cnt_q <= 3'h0;
      lead_q    <= 1'b0;
    end else begin
      if (cmd_stb && !is_flag && !do_final) begin
        dig_q     <= '0;
        dig_cnt_q <= 3'h0;
      end else if (digit_in) begin
        dig_q <= {dig_q[BCD6_W-5:0], rx_char_q[3:0]};
        if (dig_cnt_q != 3'h6) begin
          dig_cnt_q <= dig_cnt_q + 3'h1;
        end
      end
      if (do_final) begin
        lead_q <= 1'b1;
      end else if (do_locate || do_mark || do_cancel) begin
        lead_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      atype_q <= AT_BLOCK;
    end else if (cmd_ok) begin
      case (cmd)
        CMD_BLK:  atype_q <= AT_BLOCK;
        CMD_TIME: atype_q <= AT_TIME;
        CMD_SONG: atype_q <= AT_SONG;
        CMD_IDX:  atype_q <= AT_INDEX;
        default:  atype_q <= atype_q;
      endcase
    end
  end

  // search sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: if (do_locate) begin
          state_q <= ST_SEEK;
        end
        ST_SEEK: if (seek_done || do_cancel) begin
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seek_req      <= 1'b0;
      seek_addr     <= '0;
      seek_type     <= 2'h0;
      seek_lead_out <= 1'b0;
      pause_req     <= 1'b0;
      cancel_req    <= 1'b0;
    end else begin
      seek_req   <= do_locate;
      pause_req  <= seek_end || marker_hit;
      cancel_req <= do_cancel && !busy;
      if (do_locate) begin
        seek_addr     <= dig_q;
        seek_type     <= atype_q;
        seek_lead_out <= lead_q;
      end
    end
  end

  // halt marker; the address is compared in the type it was entered in
  always_comb begin
    unique case (marker_type_q)
      AT_BLOCK: cur_sel = cur_block;
      AT_TIME:  cur_sel = {8'h00, cur_time};
      AT_SONG:  cur_sel = {16'h0000, cur_track};
      AT_INDEX: cur_sel = {8'h00, cur_track, cur_index};
    endcase
  end

  assign marker_hit = marker_valid_q && mech_playing &&
                      (marker_lead_q ? mech_lead_out :
                       (!mech_lead_in && cur_sel >= marker_addr_q));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      marker_valid_q <= 1'b0;
      marker_addr_q  <= '0;
      marker_type_q  <= AT_BLOCK;
      marker_lead_q  <= 1'b0;
    end else if (do_mark) begin
      marker_valid_q <= 1'b1;
      marker_addr_q  <= atype_q == AT_INDEX ? {8'h00, dig_q[15:0]} : dig_q;
      marker_type_q  <= atype_q;
      marker_lead_q  <= lead_q;
    end else if (marker_hit || do_cancel || reject_seen) begin
      marker_valid_q <= 1'b0;
    end
  end

  // scan timer; attenuation follows the scan exactly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_fwd   <= 1'b0;
      scan_rev   <= 1'b0;
      atten_12db <= 1'b0;
      scan_cnt_q <= '0;
    end else if (do_fwd || do_rev) begin
      scan_fwd   <= do_fwd;
      scan_rev   <= do_rev;
      atten_12db <= 1'b1;
      scan_cnt_q <= SCAN_W'(SCAN_CYCLES_P - 1);
    end else if (scan_fwd || scan_rev) begin
      if (scan_cnt_q == '0) begin
        scan_fwd   <= 1'b0;
        scan_rev   <= 1'b0;
        atten_12db <= 1'b0;
      end else begin
        scan_cnt_q <= scan_cnt_q - SCAN_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level       <= LEVEL_RST;
      chan_left   <= CHAN_RST[0];
      chan_right  <= CHAN_RST[1];
      keys_locked <= 1'b0;
      comm_mode   <= PROTO_MODE;
    end else if (cmd_ok) begin
      if (cmd == CMD_LEVEL) begin
        level <= arg_bin[7:0];
      end
      if (cmd == CMD_CHAN) begin
        chan_left  <= dig_q[0];
        chan_right <= dig_q[1];
      end
      if (cmd == CMD_KLOCK) begin
        keys_locked <= dig_q[0];
      end
      if (cmd == CMD_PROTO) begin
        comm_mode <= PROTO_MODE;
      end
    end
  end

  // replies; a new reply replaces any unread one
  assign a_blk = mech_lead_in ? to_ascii(24'h0) : to_ascii(cur_block);
  assign a_tim = mech_lead_in ? to_ascii(24'h0) : to_ascii({8'h00, cur_time});
  assign a_idx = mech_lead_in ? to_ascii(24'h0) : to_ascii({8'h00, cur_track, cur_index});
  assign resp_load = cmd_err || (cmd_ok && !do_locate) || seek_end;

  always_comb begin
    resp_d     = {CH_R, CH_CR, 40'h0};
    resp_len_d = 3'h2;
    if (cmd_err) begin
      resp_d     = {CH_E, CH_0, CH_4, CH_CR, 24'h0};
      resp_len_d = 3'h4;
    end else if (cmd_ok && cmd == QRY_BLK) begin
      resp_d     = {mech_parked ? {6{CH_X}} : a_blk, CH_CR};
      resp_len_d = 3'h7;
    end else if (cmd_ok && cmd == QRY_TIME) begin
      resp_d     = {mech_parked ? {4{CH_X}} : a_tim[31:0], CH_CR, 16'h0};
      resp_len_d = 3'h5;
    end else if (cmd_ok && cmd == QRY_SONG) begin
      resp_len_d = 3'h3;
      if (mech_parked) begin
        resp_d = {{2{CH_X}}, CH_CR, 32'h0};
      end else if (mech_lead_out && !mech_lead_in) begin
        resp_d = {{2{CH_A}}, CH_CR, 32'h0};
      end else begin
        resp_d = {a_idx[31:16], CH_CR, 32'h0};
      end
    end else if (cmd_ok && cmd == QRY_IDX) begin
      resp_len_d = 3'h5;
      if (mech_parked) begin
        resp_d = {{4{CH_X}}, CH_CR, 16'h0};
      end else if (mech_lead_out && !mech_lead_in) begin
        resp_d = {CH_A, CH_A, CH_0, CH_1, CH_CR, 16'h0};
      end else begin
        resp_d = {a_idx[31:0], CH_CR, 16'h0};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_q     <= '0;
      resp_cnt_q <= 3'h0;
    end else if (resp_load) begin
      resp_q     <= resp_d;
      resp_cnt_q <= resp_len_d;
    end else if (tx_pop && resp_cnt_q != 3'h0) begin
      resp_q     <= {resp_q[RESP_W-9:0], 8'h00};
      resp_cnt_q <= resp_cnt_q - 3'h1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_seek_finish;
    (state_q == ST_SEEK) && seek_done && !do_cancel;
  endsequence

  a_fwd_scan_start: assert property (do_fwd |=> scan_fwd && atten_12db && !scan_rev)
    else $error("forward scan not started with attenuation");
  a_rev_scan_start: assert property (do_rev |=> scan_rev && atten_12db && !scan_fwd)
    else $error("reverse scan not started with attenuation");
  a_seek_then_pause: assert property (s_seek_finish |=> pause_req && resp_cnt_q == 3'h2 ##1 busy == 1'b0)
    else $error("locate did not end in pause with completion");
  a_marker_hit_pause: assert property (marker_hit && !do_mark |=> pause_req && !marker_valid_q)
    else $error("marker crossing did not pause and clear");
  a_reject_drop: assert property (reject_seen && !do_mark |=> !marker_valid_q)
    else $error("reject left the marker pending");
  a_block_flag: assert property (cmd_ok && cmd == CMD_BLK |=> atype_q == AT_BLOCK)
    else $error("block flag not taken");
  a_cancel_clear: assert property (do_cancel |=> dig_cnt_q == 3'h0 && !marker_valid_q && !busy)
    else $error("cancel left digits, marker or search");
  a_cancel_search: assert property (do_cancel && busy |=> pause_req && !cancel_req)
    else $error("cancel during search did not pause");
  a_level_set: assert property (cmd_ok && cmd == CMD_LEVEL |=> {2'b00, level} == $past(arg_bin))
    else $error("level not set from argument");
  a_proto_fixed: assert property (comm_mode == PROTO_MODE)
    else $error("protocol mode changed");
  a_proto_refuse: assert property (cmd_stb && cmd == CMD_PROTO &&
                                   arg_bin != 10'(PROTO_MODE) |-> cmd_err)
    else $error("bad protocol mode accepted");
  a_error_reply: assert property (cmd_err |=> resp_cnt_q == 3'h4 && resp_q[RESP_W-1 -: 8] == CH_E)
    else $error("error reply missing");
endmodule : dcp_cmd_interp
`default_nettype wire

// ==== dcp_mech_model.sv ====
// mechanism stand-in: answers a seek after a set delay, drops it on a pause
// assumes seek_req and pause_req are one-cycle pulses on pclk
`timescale 1ns/1ns
`default_nettype none
module dcp_mech_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        seek_req,
  input  wire logic        pause_req,
  input  wire logic [15:0] delay,
  output logic             seek_done
);
  logic [15:0] cnt_q;
  logic        busy_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q     <= 16'h0000;
      busy_q    <= 1'b0;
      seek_done <= 1'b0;
    end else begin
      seek_done <= busy_q && cnt_q == 16'h0000 && !pause_req;
      if (seek_req) begin
        cnt_q  <= delay;
        busy_q <= 1'b1;
      end else if (pause_req || cnt_q == 16'h0000) begin
        // a halted search must never report completion later
        busy_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - 16'h0001;
      end
    end
  end
endmodule : dcp_mech_model
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the command interpreter, host side over apb
// assumes the mechanism stand-in for seek completion; scan count shortened
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import dcp_pkg::*;
  localparam int SCAN_P = 50;
  logic                pclk = 1'b0;
  logic                presetn = 1'b0;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [11:0]         paddr = 12'h000;
  logic [31:0]         pwdata = 32'h0;
  logic [31:0]         prdata, st;
  logic                pready, pslverr, last_err, seek_done;
  logic                mech_playing = 1'b0, mech_parked = 1'b0;
  logic                mech_lead_in = 1'b0, mech_lead_out = 1'b0, reject_seen = 1'b0;
  logic [BCD6_W-1:0]   cur_block = 24'h0, seek_addr;
  logic [15:0]         cur_time = 16'h0, dly = 16'h0;
  logic [7:0]          cur_track = 8'h0, cur_index = 8'h0, level;
  logic                seek_req, seek_lead_out, pause_req, cancel_req;
  logic                scan_fwd, scan_rev, atten_12db, chan_left, chan_right, keys_locked;
  logic [1:0]          seek_type, comm_mode;
  int                  err_count = 0, total_checks = 0, pause_n = 0, cancel_n = 0;
  string               err_s;
  dcp_cmd_interp #(.SCAN_CYCLES_P(SCAN_P)) dcp_cmd_interp_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mech_playing,
    .mech_parked, .mech_lead_in, .mech_lead_out, .seek_done, .reject_seen, .cur_block,
    .cur_time, .cur_track, .cur_index, .seek_req, .seek_addr, .seek_type, .seek_lead_out,
    .pause_req, .cancel_req, .scan_fwd, .scan_rev, .atten_12db, .level, .chan_left,
    .chan_right, .keys_locked, .comm_mode);
  dcp_mech_model dcp_mech_model_i (.pclk, .presetn, .seek_req, .pause_req, .delay(dly),
    .seek_done);
  always #25 pclk = ~pclk;
  // pulses last one cycle, so count them rather than look for them later
  always @(posedge pclk) begin
    if (pause_req === 1'b1) pause_n <= pause_n + 1;
    if (cancel_req === 1'b1) cancel_n <= cancel_n + 1;
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  task automatic hang();
    err_count++;
    finish_test();
  endtask : hang
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    int n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) hang();
    rd       = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic string code(input logic [15:0] c);
    return $sformatf("%c%c", c[15:8], c[7:0]);
  endfunction : code
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) apb(1'b1, ADDR_RX, {24'h0, s[i]}, st);
  endtask : send
  task automatic reply(input string s);
    int n = 0;
    do begin
      apb(1'b0, ADDR_STAT, 32'h0, st);
      n++;
    end while (st[STAT_AVAIL] !== 1'b1 && n < 400);
    if (st[STAT_AVAIL] !== 1'b1) hang();
    s = {s, "\r"};
    for (int i = 0; i < s.len(); i++) begin
      apb(1'b0, ADDR_TX, 32'h0, st);
      check(st, {23'h0, 1'b1, s[i]});
    end
  endtask : reply
  task automatic cmd(input string pre, input logic [15:0] c, input string exp);
    send({pre, code(c)});
    reply(exp);
  endtask : cmd
  task automatic stat_is(input int b, input logic e);
    apb(1'b0, ADDR_STAT, 32'h0, st);
    check(32'(st[b]), 32'(e));
  endtask : stat_is
  task automatic t_settings();
    for (int v = 0; v < 8; v++) begin
      cmd($sformatf("%0d", v), CMD_CHAN, "R");
      check(32'({chan_right, chan_left}), 32'(v % 4));
    end
    cmd("0", CMD_LEVEL, "R");
    check(32'(level), 32'h0);
    cmd("255", CMD_LEVEL, "R");
    cmd("256", CMD_LEVEL, err_s);
    check(32'(level), 32'hff);
    cmd("3", CMD_PROTO, "R");
    cmd("2", CMD_PROTO, err_s);
    check(32'(comm_mode), 32'h3);
    cmd("1", CMD_KLOCK, "R");
    check(32'(keys_locked), 32'h1);
    cmd("0", CMD_KLOCK, "R");
    cmd("2", CMD_KLOCK, err_s);
    check(32'(keys_locked), 32'h0);
    cmd("", 16'h5a5a, err_s);
    apb(1'b0, 12'h00c, 32'h0, st);
    check({31'h0, last_err}, 32'h1);
  endtask : t_settings
  task automatic t_scan();
    for (int i = 0; i < 2; i++) begin
      cmd("", i ? CMD_REV : CMD_FWD, "R");
      check(32'({scan_fwd, scan_rev, atten_12db}), i ? 32'h3 : 32'h5);
      repeat (SCAN_P + 2) @(posedge pclk);
      check(32'({scan_fwd, scan_rev, atten_12db}), 32'h0);
    end
  endtask : t_scan
  task automatic t_locate();
    logic [15:0] fl[4] = '{CMD_BLK, CMD_TIME, CMD_SONG, CMD_IDX};
    string       dg[4] = '{"4500", "1234", "05", "3"};
    logic [23:0] ad[4] = '{24'h004500, 24'h001234, 24'h000005, 24'h000003};
    int          p0;
    for (int i = 0; i < 4; i++) begin
      p0 = pause_n;
      dly <= 16'(i * 20);
      cmd("", fl[i], "R");
      apb(1'b0, ADDR_STAT, 32'h0, st);
      check(32'(st[5:4]), 32'(i));
      send({dg[i], code(CMD_LOCATE)});
      if (i > 0) stat_is(STAT_BUSY, 1'b1);
      reply("R");
      check(32'(seek_addr), 32'(ad[i]));
      check(32'(seek_type), 32'(i));
      check(32'(seek_lead_out), 32'h0);
      check(32'(pause_n), 32'(p0 + 1));
    end
  endtask : t_locate
  task automatic t_cancel();
    int p0;
    int c0;
    dly <= 16'h012c;
    cmd("", CMD_BLK, "R");
    send({"000100", code(CMD_LOCATE)});
    p0 = pause_n;
    c0 = cancel_n;
    cmd("3", CMD_CHAN, err_s);
    cmd("", CMD_CANCEL, "R");
    check(32'(pause_n), 32'(p0 + 1));
    check(32'(cancel_n), 32'(c0));
    stat_is(STAT_BUSY, 1'b0);
    send("12");
    cmd("", CMD_CANCEL, "R");
    check(32'(cancel_n), 32'(c0 + 1));
    cmd("", CMD_CHAN, err_s);
  endtask : t_cancel
  task automatic t_marker();
    int p0;
    mech_playing <= 1'b1;
    cur_block    <= 24'h0;
    cmd("", CMD_BLK, "R");
    cmd("000100", CMD_MARK, "R");
    stat_is(STAT_MARK, 1'b1);
    p0 = pause_n;
    cur_block <= 24'h000100;
    repeat (4) @(posedge pclk);
    check(32'(pause_n), 32'(p0 + 1));
    stat_is(STAT_MARK, 1'b0);
    cur_block <= 24'h0;
    cmd("000100", CMD_MARK, "R");
    reject_seen <= 1'b1;
    @(posedge pclk);
    reject_seen <= 1'b0;
    stat_is(STAT_MARK, 1'b0);
    cmd("000100", CMD_MARK, "R");
    cmd("", CMD_CANCEL, "R");
    stat_is(STAT_MARK, 1'b0);
    dly <= 16'h0000;
    cmd("", CMD_FINAL, "R");
    cmd("", CMD_LOCATE, "R");
    check(32'(seek_lead_out), 32'h1);
    cmd("", CMD_FINAL, "R");
    cmd("", CMD_MARK, "R");
    p0 = pause_n;
    mech_lead_out <= 1'b1;
    repeat (4) @(posedge pclk);
    check(32'(pause_n), 32'(p0 + 1));
    mech_lead_out <= 1'b0;
  endtask : t_marker
  task automatic t_query();
    logic [15:0] q[4] = '{QRY_BLK, QRY_TIME, QRY_SONG, QRY_IDX};
    string       ex[3][4] = '{'{"XXXXXX", "XXXX", "XX", "XXXX"},
                              '{"000000", "0000", "00", "0000"},
                              '{"123456", "4512", "07", "0702"}};
    cur_block <= 24'h123456;
    cur_time  <= 16'h4512;
    cur_track <= 8'h07;
    cur_index <= 8'h02;
    for (int s = 0; s < 3; s++) begin
      mech_parked  <= (s == 0);
      mech_lead_in <= (s == 1);
      mech_playing <= (s == 2);
      for (int k = 0; k < 4; k++) cmd("", q[k], ex[s][k]);
    end
    mech_playing  <= 1'b0;
    mech_lead_out <= 1'b1;
    cmd("", QRY_SONG, "AA");
    cmd("", QRY_IDX, "AA01");
  endtask : t_query
  initial begin
    err_s = $sformatf("%c%c%c", CH_E, CH_0, CH_4);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    check(32'({level, chan_right, chan_left, keys_locked, comm_mode}), 32'h1ffb);
    t_settings();
    t_scan();
    t_locate();
    t_cancel();
    t_marker();
    t_query();
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
